//--- rtl/bmo_pkg.sv
// shared constants, states and carriers of the byte move / or execute block
package bmo_pkg;
   // ************************************************************
   // widths and counts
   // ************************************************************
   localparam int DATA_W     = 8;
   localparam int ADDR_W     = 12;
   localparam int INSTR_W    = 16;
   localparam int PTR_COUNT  = 3;
   localparam int BANK_W     = 4;
   localparam int AVS_ADDR_W = 6;
   localparam int CNT_W      = 32;

   // ************************************************************
   // opcode fields
   // ************************************************************
   localparam logic [5:0]  OPC_OR_FILE    = 6'h04;   // 0001 00
   localparam logic [5:0]  OPC_COPY_FILE  = 6'h14;   // 0101 00
   localparam logic [9:0]  OPC_PTR_LOAD1  = 10'h3b8; // 1110 1110 00
   localparam logic [7:0]  OPC_WORD2      = 8'hf0;   // 1111 0000
   localparam logic [3:0]  OPC_F2F_WORD1  = 4'hc;    // 1100
   localparam logic [3:0]  OPC_F2F_WORD2  = 4'hf;    // 1111
   localparam logic [7:0]  OPC_BANK_LOAD  = 8'h01;   // 0000 0001
   localparam int          DEST_BIT       = 9;
   localparam int          ACC_BIT        = 8;

   // ************************************************************
   // data space
   // ************************************************************
   localparam logic [7:0]        INDEXED_MAX  = 8'h5f;
   localparam logic [7:0]        ACCESS_SPLIT = 8'h60;
   localparam logic [BANK_W-1:0] ACCESS_HI    = 4'hf;
   localparam logic [BANK_W-1:0] ACCESS_LO    = 4'h0;
   localparam int                IDX_PTR      = 2;
   localparam logic [ADDR_W-1:0] ACC_ADDR     = 12'hfe8;

   // ************************************************************
   // register map, byte addresses
   // ************************************************************
   localparam logic [AVS_ADDR_W-1:0] REG_CTRL   = 6'h00;
   localparam logic [AVS_ADDR_W-1:0] REG_ACC    = 6'h04;
   localparam logic [AVS_ADDR_W-1:0] REG_BANK   = 6'h08;
   localparam logic [AVS_ADDR_W-1:0] REG_STATUS = 6'h0c;
   localparam logic [AVS_ADDR_W-1:0] REG_PTR0   = 6'h10;
   localparam logic [AVS_ADDR_W-1:0] REG_PTR1   = 6'h14;
   localparam logic [AVS_ADDR_W-1:0] REG_PTR2   = 6'h18;
   localparam logic [AVS_ADDR_W-1:0] REG_COUNT  = 6'h1c;
   localparam int CTRL_RUN_BIT = 0;
   localparam int CTRL_EXT_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h0;

   typedef enum logic [4:0] {
      ST_FETCH = 5'h01,
      ST_READ  = 5'h02,
      ST_SRC   = 5'h04,
      ST_WORD2 = 5'h08,
      ST_IDLE  = 5'h10
   } bmo_state_type;

   typedef enum logic [1:0] {
      OP_NONE = 2'h0,
      OP_OR   = 2'h1,
      OP_COPY = 2'h2,
      OP_PTR  = 2'h3
   } bmo_op_type;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic              rdEn;
      logic              wrEn;
      logic [DATA_W-1:0] wrData;
   } bmo_mem_req_type;

   typedef struct packed {
      logic negative;
      logic zero;
   } bmo_flags_type;
endpackage : bmo_pkg

//--- rtl/bmo_core.sv
// decode and execute of or-into-file, pointer load, file copy, file-to-file copy, bank load
//
// Function
// - a byte file instruction with destination bit 0 writes the accumulator, with 1 writes the file back.
// - access bit 0 addresses the access bank, access bit 1 uses the bank pick register as upper address.
// - access bit 0 with extended set enabled and file field up to 95 uses pointer 2 plus the field as address.
// - the 8-bit file field reaches any byte of the addressed 256-byte bank.
// - file copy (0101 00da) moves the file to the chosen destination in one word and sets negative and zero.
// - pointer literal load puts the upper four bits in the pointer high part first, the low byte second.
// - pointer literal load is two words, 1110 1110 00ss kkkk then 1111 0000 kkkkkkkk, with no flag change.
// - file-to-file copy carries 12-bit source and destination in words 1100 and 1111 and changes no flag.
// - file-to-file copy treats the accumulator address like any other data location.
// - bank literal load keeps only the low nibble, the upper bits read zero, no flag change.
`timescale 1ns/1ps
module bmo_core
   import bmo_pkg::*;
#(
   parameter int PTR_N = PTR_COUNT
) (
   input  wire logic                    clk_sys,
   input  wire logic                    arst_n,
   // program memory side
   input  wire logic [INSTR_W-1:0]      instrData,
   input  wire logic                    instrValid,
   output logic                         instrReady,
   // data space side
   output bmo_mem_req_type              memReq,
   input  wire logic [DATA_W-1:0]       memRdData,
   // status
   output bmo_flags_type                flags,
   // avalon-mm slave
   input  wire logic [AVS_ADDR_W-1:0]   address,
   input  wire logic                    read,
   input  wire logic                    write,
   input  wire logic [31:0]             writedata,
   input  wire logic [3:0]              byteenable,
   output logic [31:0]                  readdata,
   output logic                         waitrequest
);

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      bmo_state_type                    state;
      bmo_op_type                       op;
      logic                             isF2f;
      logic                             destFile;
      logic [ADDR_W-1:0]                effAddr;
      logic [1:0]                       ptrSel;
      logic [DATA_W-1:0]                hold;
      logic [DATA_W-1:0]                acc;
      logic [BANK_W-1:0]                bank;
      logic [PTR_N-1:0][ADDR_W-1:0]     ptr;
      bmo_flags_type                    flags;
      logic [1:0]                       ctrl;
      logic [CNT_W-1:0]                 count;
      logic                             instrReady;
      bmo_mem_req_type                  memReq;
      logic [31:0]                      readdata;
      logic                             waitrequest;
   } bmo_core_state_type;

   bmo_core_state_type r_q;
   bmo_core_state_type r_d;

   // ************************************************************
   // helpers
   // ************************************************************
   function automatic bmo_flags_type nzOf(input logic [DATA_W-1:0] v);
      bmo_flags_type f;
      f.negative = v[DATA_W-1];
      f.zero     = (v == '0);
      return f;
   endfunction : nzOf

   // full 12-bit data space address of a byte file instruction
   function automatic logic [ADDR_W-1:0] fileAddr(
      input logic [7:0]                f,
      input logic                      accessSel,
      input logic                      extEn,
      input logic [BANK_W-1:0]         bank,
      input logic [ADDR_W-1:0]         idxBase
   );
      logic [ADDR_W-1:0] a;
      a = '0;
      if (accessSel) begin
         a = {bank, f};
      end else if (extEn && (f <= INDEXED_MAX)) begin
         a = idxBase + {4'h0, f};
      end else if (f < ACCESS_SPLIT) begin
         a = {ACCESS_LO, f};
      end else begin
         a = {ACCESS_HI, f};
      end
      return a;
   endfunction : fileAddr

   // ************************************************************
   // next state
   // ************************************************************
   always_comb begin
      logic [ADDR_W-1:0] fa;
      logic [DATA_W-1:0] src;
      logic [DATA_W-1:0] res;
      logic              run;
      logic              take;
      fa   = '0;
      src  = '0;
      res  = '0;
      r_d  = r_q;
      run  = r_q.ctrl[CTRL_RUN_BIT];
      take = instrValid && r_q.instrReady;

      r_d.memReq.rdEn = 1'b0;
      r_d.memReq.wrEn = 1'b0;

      case (r_q.state)
         ST_IDLE: begin
            if (run) begin
               r_d.state = ST_FETCH;
            end
         end
         ST_FETCH: begin
            if (!run) begin
               r_d.state = ST_IDLE;
            end else if (take) begin
               r_d.count = r_q.count + 1'b1;
               r_d.op    = OP_NONE;
               r_d.isF2f = 1'b0;
               if (instrData[15:8] == OPC_BANK_LOAD) begin
                  r_d.bank = instrData[BANK_W-1:0];
               end else if (instrData[15:6] == OPC_PTR_LOAD1) begin
                  r_d.ptrSel = instrData[5:4];
                  if (instrData[5:4] < 2'(PTR_N)) begin
                     r_d.ptr[instrData[5:4]][11:8] = instrData[3:0];
                  end
                  r_d.op    = OP_PTR;
                  r_d.state = ST_WORD2;
               end else if (instrData[15:12] == OPC_F2F_WORD1) begin
                  r_d.isF2f   = 1'b1;
                  r_d.effAddr = instrData[ADDR_W-1:0];
                  r_d.memReq.addr = instrData[ADDR_W-1:0];
                  r_d.memReq.rdEn = (instrData[ADDR_W-1:0] != ACC_ADDR);
                  r_d.state = ST_SRC;
               end else if ((instrData[15:10] == OPC_OR_FILE) || (instrData[15:10] == OPC_COPY_FILE)) begin
                  fa = fileAddr(instrData[7:0], instrData[ACC_BIT], r_q.ctrl[CTRL_EXT_BIT],
                                r_q.bank, r_q.ptr[IDX_PTR]);
                  r_d.op       = (instrData[15:10] == OPC_OR_FILE) ? OP_OR : OP_COPY;
                  r_d.destFile = instrData[DEST_BIT];
                  r_d.effAddr  = fa;
                  r_d.memReq.addr = fa;
                  r_d.memReq.rdEn = (fa != ACC_ADDR);
                  r_d.state = ST_READ;
               end
               // anything else is not ours and passes as a no-op
            end
         end
         ST_READ: begin
            src = (r_q.effAddr == ACC_ADDR) ? r_q.acc : memRdData;
            res = (r_q.op == OP_OR) ? (r_q.acc | src) : src;
            r_d.flags = nzOf(res);
            if (!r_q.destFile || (r_q.effAddr == ACC_ADDR)) begin
               r_d.acc = res;
            end else begin
               r_d.memReq.addr   = r_q.effAddr;
               r_d.memReq.wrData = res;
               r_d.memReq.wrEn   = 1'b1;
            end
            r_d.state = ST_FETCH;
         end
         ST_SRC: begin
            r_d.hold  = (r_q.effAddr == ACC_ADDR) ? r_q.acc : memRdData;
            r_d.state = ST_WORD2;
         end
         ST_WORD2: begin
            if (take) begin
               r_d.count = r_q.count + 1'b1;
               r_d.state = ST_FETCH;
               if (r_q.isF2f && (instrData[15:12] == OPC_F2F_WORD2)) begin
                  // no read here, only the write at the end of the cycle
                  if (instrData[ADDR_W-1:0] == ACC_ADDR) begin
                     r_d.acc = r_q.hold;
                  end else begin
                     r_d.memReq.addr   = instrData[ADDR_W-1:0];
                     r_d.memReq.wrData = r_q.hold;
                     r_d.memReq.wrEn   = 1'b1;
                  end
               end else if ((r_q.op == OP_PTR) && (instrData[15:8] == OPC_WORD2)) begin
                  if (r_q.ptrSel < 2'(PTR_N)) begin
                     r_d.ptr[r_q.ptrSel][7:0] = instrData[7:0];
                  end
               end
               // a malformed second word drops the rest of the instruction; a pointer keeps the high bits loaded by the first word
            end
         end
         default: begin
            r_d.state = ST_IDLE;
         end
      endcase

      // ************************************************************
      // avalon-mm slave: one wait cycle, then answer
      // ************************************************************
      r_d.waitrequest = 1'b1;
      if ((read || write) && r_q.waitrequest) begin
         r_d.waitrequest = 1'b0;
         r_d.readdata    = '0;
         case (address)
            REG_CTRL:   r_d.readdata = {30'h0, r_q.ctrl};
            REG_ACC:    r_d.readdata = {24'h0, r_q.acc};
            REG_BANK:   r_d.readdata = {28'h0, r_q.bank};
            REG_STATUS: r_d.readdata = {22'h0, r_q.state, 3'h0, r_q.flags};
            REG_PTR0:   r_d.readdata = {20'h0, r_q.ptr[0]};
            REG_PTR1:   r_d.readdata = {20'h0, r_q.ptr[1]};
            REG_PTR2:   r_d.readdata = {20'h0, r_q.ptr[IDX_PTR]};
            REG_COUNT:  r_d.readdata = r_q.count;
            default:    r_d.readdata = '0;
         endcase
      end
      if (write && !r_q.waitrequest && (address == REG_CTRL) && byteenable[0]) begin
         r_d.ctrl = writedata[1:0];
      end

      // ready is registered from the next run bit, so a word is never taken and then dropped
      // when run clears; a pending second word is still accepted to finish the instruction
      r_d.instrReady = ((r_d.state == ST_FETCH) && r_d.ctrl[CTRL_RUN_BIT]) || (r_d.state == ST_WORD2);
   end

   // ************************************************************
   // registers
   // ************************************************************
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         r_q.state       <= ST_IDLE;
         r_q.op          <= OP_NONE;
         r_q.isF2f       <= 1'b0;
         r_q.destFile    <= 1'b0;
         r_q.effAddr     <= '0;
         r_q.ptrSel      <= '0;
         r_q.hold        <= '0;
         r_q.acc         <= '0;
         r_q.bank        <= '0;
         r_q.ptr         <= '0;
         r_q.flags       <= '0;
         r_q.ctrl        <= CTRL_RESET;
         r_q.count       <= '0;
         r_q.instrReady  <= 1'b0;
         r_q.memReq      <= '0;
         r_q.readdata    <= '0;
         r_q.waitrequest <= 1'b1;
      end else begin
         r_q <= r_d;
      end
   end

   assign instrReady  = r_q.instrReady;
   assign memReq      = r_q.memReq;
   assign flags       = r_q.flags;
   assign readdata    = r_q.readdata;
   assign waitrequest = r_q.waitrequest;

endmodule : bmo_core

//--- testbench/bmo_core_chk.sv
// concurrent checks on the ports of the byte move / or execute block
`timescale 1ns/1ps
module bmo_core_chk
   import bmo_pkg::*;
#(parameter int PTR_N = PTR_COUNT) (
   input wire logic               clk_sys,
   input wire logic               arst_n,
   input wire logic [INSTR_W-1:0] instrData,
   input wire logic               instrValid,
   input wire logic               instrReady,
   input bmo_mem_req_type         memReq,
   input bmo_flags_type           flags,
   input wire logic               read,
   input wire logic               write,
   input wire logic               waitrequest
);
   logic take;
   logic f2fPend_q;
   assign take = instrValid && instrReady;
   // second word of a file-to-file copy; pointer second words share the 1111 prefix
   always_ff @(posedge clk_sys or negedge arst_n)
      if (!arst_n) f2fPend_q <= 1'h0;
      else if (take) f2fPend_q <= !f2fPend_q && instrData[15:12] == OPC_F2F_WORD1;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest) else $error("bus answer late");
   a_wait_short: assert property (!waitrequest |=> waitrequest) else $error("bus answer held");
   a_rd_pulse: assert property (memReq.rdEn |=> !memReq.rdEn) else $error("read strobe too long");
   a_wr_pulse: assert property (memReq.wrEn |=> !memReq.wrEn) else $error("write strobe too long");
   a_rd_wr_excl: assert property (!(memReq.rdEn && memReq.wrEn)) else $error("read with write");
   // the accumulator slot is never on the memory bus, so it is left out
   a_or_read: assert property (take && instrData[15:10] == OPC_OR_FILE && instrData[7:0] != 8'he8
      |=> memReq.rdEn && !instrReady) else $error("or did not read file");
   a_copy_bank: assert property (take && instrData[15:10] == OPC_COPY_FILE && instrData[ACC_BIT]
      && instrData[7:0] != 8'he8 |=> memReq.rdEn && memReq.addr[7:0] == $past(instrData[7:0]))
      else $error("copy address wrong");
   a_f2f_src: assert property (take && !f2fPend_q && instrData[15:12] == OPC_F2F_WORD1
      && instrData[11:0] != ACC_ADDR |=> memReq.rdEn && memReq.addr == $past(instrData[11:0]))
      else $error("source read wrong");
   a_f2f_dst: assert property (take && f2fPend_q && instrData[11:0] != ACC_ADDR
      |=> memReq.wrEn && !memReq.rdEn && memReq.addr == $past(instrData[11:0])) else $error("dest write wrong");
   a_f2f_flags: assert property (take && f2fPend_q |=> $stable(flags)) else $error("copy changed flags");
   a_bank_fast: assert property (take && instrData[15:8] == OPC_BANK_LOAD |=> instrReady)
      else $error("bank load stalled");
   c_f2f: cover property (take && f2fPend_q);
   c_or: cover property (take && instrData[15:10] == OPC_OR_FILE);
   c_bus: cover property ((read || write) && !waitrequest);
endmodule : bmo_core_chk

bind bmo_core bmo_core_chk #(.PTR_N(PTR_N)) bmo_core_chk_inst (.clk_sys, .arst_n, .instrData, .instrValid,
   .instrReady, .memReq, .flags, .read, .write, .waitrequest);

//--- testbench/bmo_prog_mem.sv
// program and data memory model facing the block
`timescale 1ns/1ps
module bmo_prog_mem
   import bmo_pkg::*;
(
   input wire logic                clk_sys,
   input wire logic                arst_n,
   input wire logic                slow,
   input wire logic                instrReady,
   output logic [INSTR_W-1:0]      instrData,
   output logic                    instrValid,
   input bmo_mem_req_type          memReq,
   output logic [DATA_W-1:0]       memRdData
);
   logic [INSTR_W-1:0] prog [0:63] = '{default: 16'h0};
   logic [DATA_W-1:0]  mem [0:4095] = '{default: 8'h00};
   int                 nWords = 0;
   int                 idx_q;
   logic               gap_q;
   // an offered word stays until taken; slow mode only delays the next offer
   assign instrValid = idx_q < nWords && !gap_q;
   // no stale word or byte shows outside an offer or a read strobe
   assign instrData = instrValid ? prog[idx_q] : ~prog[idx_q];
   assign memRdData = memReq.rdEn ? mem[memReq.addr] : ~mem[memReq.addr];
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         idx_q <= 0;
         gap_q <= 1'h0;
      end else begin
         gap_q <= slow && instrValid && instrReady;
         if (instrValid && instrReady) idx_q <= idx_q + 1;
         if (memReq.wrEn) mem[memReq.addr] <= memReq.wrData;
      end
   end
endmodule : bmo_prog_mem

//--- testbench/bmo_core_bench.sv
// self-checking bench of the byte move / or execute block
`timescale 1ns/1ps
module bmo_core_bench
   import bmo_pkg::*;
;
   logic                  clk_sys = 1'h0, arst_n = 1'h0, slow = 1'h0, read = 1'h0, write = 1'h0;
   logic                  instrReady, instrValid, waitrequest;
   logic [INSTR_W-1:0]    instrData;
   bmo_mem_req_type       memReq;
   logic [DATA_W-1:0]     memRdData;
   bmo_flags_type         flags;
   logic [AVS_ADDR_W-1:0] address = 6'h00;
   logic [31:0]           writedata = 32'h0, readdata, q;
   logic [3:0]            byteenable = 4'hf;
   int                    n_fail = 0, checked = 0;
   always #20 clk_sys = ~clk_sys;
   bmo_core bmo_core_inst (.clk_sys, .arst_n, .instrData, .instrValid, .instrReady, .memReq, .memRdData,
      .flags, .address, .read, .write, .writedata, .byteenable, .readdata, .waitrequest);
   bmo_prog_mem bmo_prog_mem_inst (.clk_sys, .arst_n, .slow, .instrReady, .instrData, .instrValid, .memReq,
      .memRdData);
   task check(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task avs(input logic wr, input logic [5:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      read <= !wr;
      write <= wr;
      address <= a;
      writedata <= d;
      // waits as long as the slave asks; only the watchdog ends a hang
      do begin
         @(posedge clk_sys);
      end while (waitrequest !== 1'h0);
      q = readdata;
      read <= 1'h0;
      write <= 1'h0;
   endtask : avs
   task rd_chk(input logic [5:0] a, input logic [31:0] exp);
      avs(1'h0, a, 32'h0);
      check(q, exp);
   endtask : rd_chk
   task emit(input logic [15:0] w);
      @(posedge clk_sys);
      bmo_prog_mem_inst.prog[bmo_prog_mem_inst.nWords] <= w;
      bmo_prog_mem_inst.nWords <= bmo_prog_mem_inst.nWords + 1;
   endtask : emit
   // offer a word, wait until the block is back fetching, then judge accumulator and flags
   task step(input logic [15:0] w, input logic [7:0] acc, input logic [1:0] nz);
      int k;
      emit(w);
      k = 0;
      do begin
         avs(1'h0, REG_STATUS, 32'h0);
         k++;
      end while ((bmo_prog_mem_inst.idx_q != bmo_prog_mem_inst.nWords || q[9:5] !== 5'h01) && k < 40);
      if (k >= 40) begin
         n_fail++;
         finish_test;
      end
      rd_chk(REG_ACC, {24'h0, acc});
      rd_chk(REG_STATUS, {30'h8, nz});
   endtask : step
   task t_reset;
      check({31'h0, waitrequest}, 32'h1);
      rd_chk(REG_STATUS, 32'h200);
      rd_chk(6'h20, 32'h0);
      avs(1'h1, REG_STATUS, 32'hff);
      rd_chk(REG_STATUS, 32'h200);
      @(posedge clk_sys);
      byteenable <= 4'he;
      avs(1'h1, REG_CTRL, 32'h1);
      rd_chk(REG_CTRL, 32'h0);
      byteenable <= 4'hf;
   endtask : t_reset
   task t_bank;
      avs(1'h1, REG_CTRL, 32'h1);
      step(16'h01a5, 8'h00, 2'h0);
      rd_chk(REG_BANK, 32'h5);
   endtask : t_bank
   task t_or;
      bmo_prog_mem_inst.mem[12'h510] = 8'h00;
      bmo_prog_mem_inst.mem[12'h511] = 8'h81;
      bmo_prog_mem_inst.mem[12'hf70] = 8'h02;
      bmo_prog_mem_inst.mem[12'h020] = 8'h40;
      step(16'h5110, 8'h00, 2'h1);
      step(16'h1111, 8'h81, 2'h2);
      step(16'h1270, 8'h81, 2'h2);
      check(bmo_prog_mem_inst.mem[12'hf70], 8'h83);
      step(16'h5020, 8'h40, 2'h0);
      step(16'h53ff, 8'h40, 2'h1);
      check(bmo_prog_mem_inst.mem[12'h5ff], 8'h00);
   endtask : t_or
   task t_ptr;
      emit(16'hee23);
      step(16'hf0ab, 8'h40, 2'h1);
      rd_chk(REG_PTR2, 32'h3ab);
      emit(16'hee01);
      step(16'hf0ff, 8'h40, 2'h1);
      rd_chk(REG_PTR0, 32'h1ff);
      // selector 3 names no pointer: nothing may change
      emit(16'hee35);
      step(16'hf077, 8'h40, 2'h1);
      rd_chk(REG_PTR1, 32'h0);
      rd_chk(REG_PTR2, 32'h3ab);
      avs(1'h1, REG_CTRL, 32'h3);
      bmo_prog_mem_inst.mem[12'h3b0] = 8'h7e;
      bmo_prog_mem_inst.mem[12'hf60] = 8'h00;
      step(16'h5005, 8'h7e, 2'h0);
      step(16'h5060, 8'h00, 2'h1);
   endtask : t_ptr
   task t_f2f;
      slow <= 1'h1;
      bmo_prog_mem_inst.mem[12'h123] = 8'h9c;
      // destinations stay clear of the program counter and stack top bytes
      emit(16'hc123);
      step(16'hffe8, 8'h9c, 2'h1);
      emit(16'hcfe8);
      step(16'hf456, 8'h9c, 2'h1);
      check(bmo_prog_mem_inst.mem[12'h456], 8'h9c);
      rd_chk(REG_COUNT, 32'h12);
   endtask : t_f2f
   task t_rerun;
      @(posedge clk_sys);
      arst_n <= 1'h0;
      repeat (2) @(posedge clk_sys);
      check({31'h0, instrReady}, 32'h0);
      arst_n <= 1'h1;
      rd_chk(REG_STATUS, 32'h200);
      rd_chk(REG_BANK, 32'h0);
      rd_chk(REG_PTR2, 32'h0);
   endtask : t_rerun
   task finish_test;
      if (n_fail == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask : finish_test
   initial begin
      repeat (2) @(posedge clk_sys);
      arst_n <= 1'h1;
      t_reset;
      t_bank;
      t_or;
      t_ptr;
      t_f2f;
      t_rerun;
      finish_test;
   end
   // 18 instruction words of some 20 cycles each fit well inside this span
   initial begin
      repeat (5000) @(posedge clk_sys);
      n_fail++;
      finish_test;
   end
endmodule : bmo_core_bench
